// ---- rtl/dhcp_regs.vh ----
// Behaviour
// - Set stage power-off bit powers stage down
// - Bypass bits remove sinc filter, multiplier
// - All four power-off bits mean full power-down
// - Port-select pin picks parallel or serial
// - Writes land in buffer, copied later
// - Copy on timer or external update request
// - Access without reference; copy needs reference
// - Master reset restores interface and defaults
// - Parallel port: address, data, two strobes
// - One byte per parallel write, back-to-back; the code needs a few clocks between write strobes
// - All registers reachable from both ports
// - Multiplier field binary, valid four to twenty
// - Serial uses one shared or two pins
// - Serial supports both bit orders
// - Serial mode ignores parallel-only pins
// - Reference start forces copy into bank
`ifndef DHCP_REGS_VH
`define DHCP_REGS_VH

// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define DHCP_OFS_UPD0 6'h16
`define DHCP_OFS_UPD1 6'h17
`define DHCP_OFS_UPD2 6'h18
`define DHCP_OFS_UPD3 6'h19
`define DHCP_OFS_PWR 6'h1d
`define DHCP_OFS_CLK 6'h1e
`define DHCP_OFS_UPDMODE 6'h1f
`define DHCP_OFS_BYP 6'h20

// ----------------------------------------
// Field positions and multiplier limits
// ----------------------------------------
`define DHCP_MULT_MSB 4
`define DHCP_PLL_BYP_BIT 5
`define DHCP_INT_UPD_BIT 0
`define DHCP_BYP_SINC_BIT 6
`define DHCP_BYP_MULT_BIT 5
`define DHCP_SER_LSB_BIT 1
`define DHCP_SER_SDO_BIT 0
`define DHCP_SER_RD_BIT 7
`define DHCP_MULT_MIN 5'h04
`define DHCP_MULT_MAX 5'h14

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DHCP_DEF_BYTE 8'h00
`define DHCP_DEF_UPDMODE 8'h01

// ----------------------------------------
// Timing
// ----------------------------------------
`define DHCP_REF_TIMEOUT 8'h40

`endif

// ---- rtl/dhcp_port.v ----
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "dhcp_regs.vh"

module dhcp_port #(
  parameter ADDR_W = 6,
  parameter DEPTH = 64
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_master_reset,
  input wire i_port_sel,
  input wire [5:0] i_par_addr,
  input wire [7:0] i_par_data_in,
  output reg [7:0] o_par_data_out,
  output reg o_par_data_oe_n,
  input wire i_par_wr_n,
  input wire i_par_rd_n,
  input wire i_sclk,
  input wire i_cs_n,
  input wire i_sdio_in,
  output reg o_sdio_out,
  output reg o_sdio_oe_n,
  output reg o_serial_out_line,
  input wire i_reference_clock_input,
  input wire i_io_update,
  output reg [3:0] o_stage_power_off_bit,
  output reg o_full_power_down,
  output reg o_bypass_inv_sinc,
  output reg o_bypass_dig_mult,
  output reg [4:0] o_ref_mult,
  output reg o_ref_mult_valid,
  output reg o_pll_bypass,
  output reg o_ext_update_mode,
  output reg o_update_pulse,
  output reg o_ref_running
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // All pins sampled by two flops; addr and data share the strobe delay
  // Reset to idle pin levels so no false strobe edge follows reset
  localparam SW = 23;
  localparam [SW-1:0] SYNC_IDLE = {16'h0000, 7'h68};
  wire [SW-1:0] pins;
  reg [SW-1:0] sync1;
  reg [SW-1:0] sync2;
  assign pins = {i_master_reset, i_port_sel, i_par_addr, i_par_data_in, i_par_wr_n,
                 i_par_rd_n, i_sclk, i_cs_n, i_sdio_in, i_reference_clock_input,
                 i_io_update};

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
    end
    else
    begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  wire s_mreset = sync2[22];
  wire s_par_mode = sync2[21];
  wire [5:0] s_addr = sync2[20:15];
  wire [7:0] s_data = sync2[14:7];
  wire s_wr_n = sync2[6];
  wire s_rd_n = sync2[5];
  wire s_sclk = sync2[4];
  wire s_cs_n = sync2[3];
  wire s_sdi = sync2[2];
  wire s_ref = sync2[1];
  wire s_upd = sync2[0];

  reg wr_n_d;
  reg sclk_d;
  reg ref_d;
  reg upd_d;
  wire init = i_rst | s_mreset;

  // ----------------------------------------
  // Buffer and active bank
  // ----------------------------------------
  reg [7:0] buf_mem [0:DEPTH-1];
  reg [7:0] bank [0:DEPTH-1];
  reg buf_we;
  reg [ADDR_W-1:0] buf_wa;
  reg [7:0] buf_wd;
  reg do_copy;
  integer k;

  function [7:0] def_val;
    input integer a;
    begin
      if (a == `DHCP_OFS_UPDMODE)
        def_val = `DHCP_DEF_UPDMODE;
      else
        def_val = `DHCP_DEF_BYTE;
    end
  endfunction

  always @(posedge i_clk)
  begin
    if (init)
    begin
      for (k = 0; k < DEPTH; k = k + 1)
      begin
        buf_mem[k] <= def_val(k);
        bank[k] <= def_val(k);
      end
    end
    else
    begin
      if (buf_we)
        buf_mem[buf_wa] <= buf_wd;
      if (do_copy)
        for (k = 0; k < DEPTH; k = k + 1)
          bank[k] <= buf_mem[k];
    end
  end

  // ----------------------------------------
  // Parallel port
  // ----------------------------------------
  // Strobe sampling limits write spacing to a few clocks, not 10.5 ns
  reg par_we;
  always @(posedge i_clk)
  begin
    if (init)
    begin
      wr_n_d <= 1'b1;
      o_par_data_out <= 8'h00;
      o_par_data_oe_n <= 1'b1;
    end
    else
    begin
      wr_n_d <= s_wr_n;
      o_par_data_oe_n <= ~(s_par_mode & ~s_rd_n);
      o_par_data_out <= buf_mem[s_addr];
    end
  end

  always @*
  begin
    par_we = s_par_mode & wr_n_d & ~s_wr_n;
  end

  // ----------------------------------------
  // Serial port
  // ----------------------------------------
  // Frame: instruction byte (read flag, byte address), then one data byte
  reg [4:0] bit_cnt;
  reg [7:0] in_sh;
  reg [7:0] out_sh;
  reg [7:0] instr;
  reg ser_we;
  reg [7:0] next_in;
  wire ser_on = ~s_par_mode & ~s_cs_n;
  wire lsb_first = bank[`DHCP_OFS_BYP][`DHCP_SER_LSB_BIT];
  wire sdo_pin = bank[`DHCP_OFS_BYP][`DHCP_SER_SDO_BIT];
  wire sclk_rise = ser_on & s_sclk & ~sclk_d;
  wire sclk_fall = ser_on & ~s_sclk & sclk_d;
  wire rd_phase = instr[`DHCP_SER_RD_BIT] & (bit_cnt >= 5'd8);

  always @*
  begin
    if (lsb_first)
      next_in = {s_sdi, in_sh[7:1]};
    else
      next_in = {in_sh[6:0], s_sdi};
  end

  always @(posedge i_clk)
  begin
    if (init)
    begin
      sclk_d <= 1'b0;
      bit_cnt <= 5'd0;
      in_sh <= 8'h00;
      out_sh <= 8'h00;
      instr <= 8'h00;
      ser_we <= 1'b0;
      o_sdio_out <= 1'b0;
      o_sdio_oe_n <= 1'b1;
      o_serial_out_line <= 1'b0;
    end
    else
    begin
      sclk_d <= s_sclk;
      ser_we <= 1'b0;
      if (!ser_on)
      begin
        bit_cnt <= 5'd0;
        instr <= 8'h00;
      end
      else if (sclk_rise && bit_cnt < 5'd16)
      begin
        in_sh <= next_in;
        bit_cnt <= bit_cnt + 5'd1;
        if (bit_cnt == 5'd7)
        begin
          instr <= next_in;
          out_sh <= buf_mem[next_in[5:0]];
        end
        if (bit_cnt == 5'd15 && !instr[`DHCP_SER_RD_BIT])
          ser_we <= 1'b1;
      end
      else if (sclk_fall && rd_phase && bit_cnt < 5'd16)
      begin
        if (lsb_first)
        begin
          o_sdio_out <= out_sh[0];
          o_serial_out_line <= out_sh[0];
          out_sh <= {1'b0, out_sh[7:1]};
        end
        else
        begin
          o_sdio_out <= out_sh[7];
          o_serial_out_line <= out_sh[7];
          out_sh <= {out_sh[6:0], 1'b0};
        end
      end
      o_sdio_oe_n <= ~(ser_on & rd_phase & ~sdo_pin);
    end
  end

  // Serial write uses bytes latched at end of frame
  always @*
  begin
    buf_we = 1'b0;
    buf_wa = s_addr;
    buf_wd = s_data;
    if (par_we)
      buf_we = 1'b1;
    else if (ser_we)
    begin
      buf_we = 1'b1;
      buf_wa = instr[5:0];
      buf_wd = in_sh;
    end
  end

  // ----------------------------------------
  // Reference clock monitor
  // ----------------------------------------
  reg [7:0] ref_idle;
  reg ref_run_d;
  always @(posedge i_clk)
  begin
    if (init)
    begin
      ref_d <= 1'b0;
      ref_idle <= `DHCP_REF_TIMEOUT;
      o_ref_running <= 1'b0;
      ref_run_d <= 1'b0;
    end
    else
    begin
      ref_d <= s_ref;
      ref_run_d <= o_ref_running;
      if (s_ref && !ref_d)
        ref_idle <= 8'h00;
      else if (ref_idle != `DHCP_REF_TIMEOUT)
        ref_idle <= ref_idle + 8'h01;
      o_ref_running <= (ref_idle != `DHCP_REF_TIMEOUT);
    end
  end

  // ----------------------------------------
  // Update control
  // ----------------------------------------
  reg [31:0] upd_cnt;
  wire int_mode = bank[`DHCP_OFS_UPDMODE][`DHCP_INT_UPD_BIT];
  wire [31:0] upd_rate = {bank[`DHCP_OFS_UPD0], bank[`DHCP_OFS_UPD1],
                          bank[`DHCP_OFS_UPD2], bank[`DHCP_OFS_UPD3]};
  wire ref_start = o_ref_running & ~ref_run_d;
  wire ext_req = ~int_mode & s_upd & ~upd_d;
  wire int_req = int_mode & (upd_cnt == 32'h0000_0000);

  always @*
  begin
    // No copy without a running reference
    do_copy = o_ref_running & (ref_start | ext_req | int_req);
  end

  always @(posedge i_clk)
  begin
    if (init)
    begin
      upd_d <= 1'b0;
      upd_cnt <= 32'h0000_0000;
      o_update_pulse <= 1'b0;
    end
    else
    begin
      upd_d <= s_upd;
      o_update_pulse <= do_copy;
      if (!o_ref_running || int_req)
        upd_cnt <= upd_rate;
      else
        upd_cnt <= upd_cnt - 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // Control outputs from active bank
  // ----------------------------------------
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_stage_power_off_bit <= 4'h0;
      o_full_power_down <= 1'b0;
      o_bypass_inv_sinc <= 1'b0;
      o_bypass_dig_mult <= 1'b0;
      o_ref_mult <= 5'h00;
      o_ref_mult_valid <= 1'b0;
      o_pll_bypass <= 1'b0;
      o_ext_update_mode <= 1'b0;
    end
    else
    begin
      o_stage_power_off_bit <= bank[`DHCP_OFS_PWR][3:0];
      o_full_power_down <= &bank[`DHCP_OFS_PWR][3:0];
      o_bypass_inv_sinc <= bank[`DHCP_OFS_BYP][`DHCP_BYP_SINC_BIT];
      o_bypass_dig_mult <= bank[`DHCP_OFS_BYP][`DHCP_BYP_MULT_BIT];
      o_ref_mult <= bank[`DHCP_OFS_CLK][`DHCP_MULT_MSB:0];
      o_ref_mult_valid <= (bank[`DHCP_OFS_CLK][`DHCP_MULT_MSB:0] >= `DHCP_MULT_MIN) &&
                          (bank[`DHCP_OFS_CLK][`DHCP_MULT_MSB:0] <= `DHCP_MULT_MAX);
      o_pll_bypass <= bank[`DHCP_OFS_CLK][`DHCP_PLL_BYP_BIT];
      o_ext_update_mode <= ~int_mode;
    end
  end

endmodule

// ---- bench/dhcp_host.sv ----
`timescale 1ns/1ps
// ----
// Host model
// ----
module dhcp_host (
  input wire i_clk,
  input wire [7:0] i_dout,
  input wire i_oe_n,
  input wire i_sdo,
  input wire i_sdo_oe_n,
  input wire i_sol,
  output reg [5:0] o_a,
  output wire [7:0] o_pd,
  output reg o_wr_n,
  output reg o_rd_n,
  output reg o_sclk,
  output reg o_cs_n,
  output wire o_sdio
);
  reg [7:0] hd = 8'h00;
  reg hoe = 1'b0;
  reg hb = 1'b0;
  reg [7:0] q;
  event got;
  // Released lines show the inverse of the last value, never a stale copy
  assign o_pd = !i_oe_n ? i_dout : hd;
  assign o_sdio = hoe ? hb : !i_sdo_oe_n ? i_sdo : ~hb;
  initial {o_a, o_wr_n, o_rd_n, o_sclk, o_cs_n} = {6'h00, 4'hd};
  task pwr(input [5:0] a, input [7:0] d);
    @(posedge i_clk);
    o_a <= a;
    hd <= d;
    o_wr_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    o_wr_n <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask
  task prd(input [5:0] a);
    @(posedge i_clk);
    o_a <= a;
    hd <= ~hd;
    o_rd_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    o_rd_n <= 1'b1;
    repeat (5) @(posedge i_clk);
  endtask
  // Serial clock stands low between frames; offset keeps it off clk edges
  task ser(input rd, input [5:0] a, input [7:0] d, input lsb);
    reg [15:0] w;
    integer i;
    w = {rd, 1'b0, a, d};
    @(posedge i_clk);
    #7;
    o_cs_n <= 1'b0;
    for (i = 0; i < 16; i = i + 1)
    begin
      hoe <= !(rd && i > 7);
      hb <= w[lsb ? (i < 8 ? i + 8 : i - 8) : 15 - i];
      #80;
      o_sclk <= 1'b1;
      if (rd && i > 7) q[lsb ? i - 8 : 15 - i] = lsb ? i_sol : o_sdio;
      #80;
      o_sclk <= 1'b0;
    end
    #80;
    o_cs_n <= 1'b1;
    hoe <= 1'b0;
    if (rd) -> got;
    #400;
  endtask
endmodule

// ---- bench/dhcp_sva.sv ----
`timescale 1ns/1ps
// ----
// Port checks
// ----
module dhcp_sva (
  input wire i_clk,
  input wire i_rst,
  input wire i_master_reset,
  input wire i_port_sel,
  input wire i_par_rd_n,
  input wire o_par_data_oe_n,
  input wire [3:0] o_stage_power_off_bit,
  input wire o_full_power_down,
  input wire o_bypass_inv_sinc,
  input wire [4:0] o_ref_mult,
  input wire o_ref_mult_valid,
  input wire o_ext_update_mode,
  input wire o_update_pulse,
  input wire o_ref_running
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  chk_full_down: assert property (
    o_full_power_down == &o_stage_power_off_bit) else $error("full power-down wrong");
  chk_mult_range: assert property (
    o_ref_mult_valid == (o_ref_mult >= 5'h04 && o_ref_mult <= 5'h14))
    else $error("multiplier valid wrong");
  chk_copy_only: assert property (
    $changed({o_stage_power_off_bit, o_bypass_inv_sinc, o_ref_mult}) && !i_master_reset
    && !$past(i_master_reset) |-> $past(o_update_pulse)) else $error("change without copy");
  chk_copy_ref: assert property (
    o_update_pulse |-> o_ref_running || $past(o_ref_running)) else $error("copy without ref");
  chk_reset_quiet: assert property (
    i_master_reset [*5] |=> !o_update_pulse) else $error("copy in master reset");
  chk_reset_defs: assert property (
    i_master_reset [*8] |-> o_stage_power_off_bit == 4'h0 && !o_bypass_inv_sinc
    && !o_ext_update_mode) else $error("defaults not loaded");
  chk_serial_idle: assert property (
    !i_port_sel [*4] |-> o_par_data_oe_n) else $error("bus driven in serial mode");
  chk_read_drive: assert property (
    i_port_sel && $fell(i_par_rd_n) ##1 (i_port_sel && !i_par_rd_n) [*2]
    |=> !o_par_data_oe_n) else $error("read data late");
  chk_read_done: assert property (
    $rose(i_par_rd_n) ##1 i_par_rd_n [*2] |=> o_par_data_oe_n) else $error("bus held");
endmodule
bind dhcp_port dhcp_sva u_sva (.*);

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`include "dhcp_regs.vh"
module tb_top;
  reg i_clk = 1'b0, i_rst = 1'b1, i_master_reset = 1'b0, i_port_sel = 1'b1;
  reg i_reference_clock_input = 1'b0, i_io_update = 1'b0, ref_on = 1'b0, poe = 1'b1;
  reg [7:0] p, b, m;
  reg [31:0] r;
  reg [7:0] expq [$];
  integer bad_count = 0, compares = 0, seed = 71, k;
  wire [5:0] i_par_addr;
  wire [7:0] i_par_data_in, o_par_data_out;
  wire [3:0] o_stage_power_off_bit;
  wire [4:0] o_ref_mult;
  wire i_par_wr_n, i_par_rd_n, i_sclk, i_cs_n, i_sdio_in, o_par_data_oe_n, o_sdio_out;
  wire o_sdio_oe_n, o_serial_out_line, o_full_power_down, o_bypass_inv_sinc;
  wire o_bypass_dig_mult, o_ref_mult_valid, o_pll_bypass, o_ext_update_mode;
  wire o_update_pulse, o_ref_running;
  wire [7:0] ov = {o_stage_power_off_bit, o_full_power_down, o_bypass_inv_sinc,
    o_bypass_dig_mult, o_ext_update_mode};
  wire [7:0] mv = {1'b0, o_pll_bypass, o_ref_mult_valid, o_ref_mult};
  dhcp_port DUT (.*);
  dhcp_host host (.i_clk(i_clk), .i_dout(o_par_data_out), .i_oe_n(o_par_data_oe_n),
    .i_sdo(o_sdio_out), .i_sdo_oe_n(o_sdio_oe_n), .i_sol(o_serial_out_line),
    .o_a(i_par_addr), .o_pd(i_par_data_in), .o_wr_n(i_par_wr_n), .o_rd_n(i_par_rd_n),
    .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_sdio(i_sdio_in));
  always #10 i_clk = ~i_clk;
  // Odd offset keeps reference edges clear of system clock edges
  initial #3 forever #45 if (ref_on) i_reference_clock_input = ~i_reference_clock_input;
  function [7:0] eo(input [7:0] pw, input [7:0] by);
    eo = {pw[3:0], &pw[3:0], by[6], by[5], 1'b1};
  endfunction
  function [7:0] em(input [7:0] mu);
    em = {1'b0, mu[5], mu[4:0] >= `DHCP_MULT_MIN && mu[4:0] <= `DHCP_MULT_MAX, mu[4:0]};
  endfunction
  task cmp(input [7:0] g, input [7:0] e);
    compares = compares + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task pop(input [7:0] g);
    if (expq.size() > 0)
      cmp(g, expq.pop_front());
    else
      cmp(g, 8'hxx);
  endtask
  task upd;
    @(posedge i_clk);
    i_io_update <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_io_update <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask
  task mres;
    @(posedge i_clk);
    i_master_reset <= 1'b1;
    repeat (12) @(posedge i_clk);
    i_master_reset <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask
  task give_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    if (poe && o_par_data_oe_n === 1'b0) pop(o_par_data_out);
    poe <= o_par_data_oe_n === 1'b1;
  end
  always @(host.got) pop(host.q);
  initial
  begin
    #300000;
    bad_count = bad_count + 1;
    give_verdict;
  end
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    mres;
    host.pwr(`DHCP_OFS_UPDMODE, 8'h00);
    host.pwr(`DHCP_OFS_PWR, 8'h0f);
    host.pwr(`DHCP_OFS_BYP, 8'h60);
    host.pwr(`DHCP_OFS_CLK, 8'h14);
    expq.push_back(8'h0f);
    host.prd(`DHCP_OFS_PWR);
    repeat (100) @(posedge i_clk);
    cmp(ov, 8'h00);
    cmp({7'h00, o_ref_running}, 8'h00);
    ref_on = 1'b1;
    repeat (80) @(posedge i_clk);
    cmp(ov, eo(8'h0f, 8'h60));
    cmp({7'h00, o_ref_running}, 8'h01);
    p = 8'h0f;
    b = 8'h60;
    m = 8'h14;
    for (k = 0; k < 7; k = k + 1)
    begin
      r = $random(seed);
      r[21:16] = k == 0 ? 6'h03 : k == 1 ? 6'h04 : k == 2 ? 6'h15 : k == 3 ? 6'h34 : r[21:16];
      host.pwr(`DHCP_OFS_PWR, r[7:0]);
      host.pwr(`DHCP_OFS_BYP, r[15:8] & 8'h60);
      host.pwr(`DHCP_OFS_CLK, {2'b00, r[21:16]});
      cmp(ov, eo(p, b));
      p = r[7:0];
      b = r[15:8] & 8'h60;
      m = {2'b00, r[21:16]};
      upd;
      cmp(ov, eo(p, b));
      cmp(mv, em(m));
    end
    i_port_sel <= 1'b0;
    repeat (8) @(posedge i_clk);
    host.pwr(`DHCP_OFS_PWR, 8'h05);
    host.prd(`DHCP_OFS_PWR);
    expq.push_back(p);
    host.ser(1'b1, `DHCP_OFS_PWR, 8'h00, 1'b0);
    host.ser(1'b0, `DHCP_OFS_PWR, 8'h0a, 1'b0);
    expq.push_back(8'h0a);
    host.ser(1'b1, `DHCP_OFS_PWR, 8'h00, 1'b0);
    host.ser(1'b0, `DHCP_OFS_BYP, 8'h03, 1'b0);
    upd;
    cmp(ov, eo(8'h0a, 8'h03));
    host.ser(1'b0, `DHCP_OFS_CLK, 8'h09, 1'b1);
    expq.push_back(8'h09);
    host.ser(1'b1, `DHCP_OFS_CLK, 8'h00, 1'b1);
    upd;
    cmp(mv, em(8'h09));
    mres;
    cmp(ov, 8'h00);
    cmp(mv, 8'h00);
    host.ser(1'b0, `DHCP_OFS_PWR, 8'h03, 1'b0);
    repeat (40) @(posedge i_clk);
    cmp(ov, 8'h30);
    cmp(8'(expq.size()), 8'h00);
    give_verdict;
  end
endmodule
